// ### psu_cmd_defs.svh
`ifndef PSU_CMD_DEFS_SVH
`define PSU_CMD_DEFS_SVH
// Operation
// - power-up policy reads back as OFF or LAST
// - OFF starts output off; LAST restores it, locks it on until reset command
// - fault clear releases latches; overvoltage and overcurrent always latch
// - overtemperature and input-fail latch under OFF, not under LAST
// - clear succeeds only once every fault cause has gone
// - after a clear the output returns to its pre-fault on/off state
// - current setpoint accepts zero to rated current, reads back programmed
// - overcurrent level accepts 10 to 110 percent of rated current
// - MIN copies current setpoint, MAX and reset command give 110 percent
// - remotely written overcurrent level takes effect on return to local
// - foldback on, constant current above level for 0.5 s: output off
// - foldback enable is one bit, reads back 1 or 0
// - trip query reads 1 once overcurrent protection tripped, else 0
// - ramp-down time 0.0 to 9.9 s, reads back
// - ramp-up time 0.0 to 9.9 s, reads back
// - memory clear erases every stored voltage and current slot
// - slot current store limited to zero through rated current
// - slot voltage store limited to zero through rated voltage
// - per-slot reads return stored current or voltage of selected slot
// - slot list read returns voltage then current of selected slot
// - slot index 0 to 15; recall copies slot into active setpoints
// - recall moves output only when on; when off only setpoints change

// ==========================================================
// register byte offsets
`define OFS_OUT_CTRL  8'h00
`define OFS_PON       8'h04
`define OFS_COMMAND   8'h08
`define OFS_CURR_SP   8'h0c
`define OFS_OCL       8'h10
`define OFS_FOLDBACK  8'h14
`define OFS_STATUS    8'h18
`define OFS_RAMP_DOWN 8'h1c
`define OFS_RAMP_UP   8'h20
`define OFS_SLOT_SEL  8'h24
`define OFS_SLOT_VOLT 8'h28
`define OFS_SLOT_CURR 8'h2c
`define OFS_VOLT_SP   8'h30
`define OFS_OCL_ACT   8'h34
`define OFS_SLOT_LIST 8'h38

// ==========================================================
// field positions
`define CMD_FAULT_CLR 0
`define CMD_MEM_CLR   1
`define CMD_RECALL    2
`define CMD_RESET     3
`define CMD_LOCAL     4
`define OCL_MIN_BIT   30
`define OCL_MAX_BIT   31
`define ST_OUTPUT     0
`define ST_TRIP       1
`define ST_OV         2
`define ST_OT         3
`define ST_ACFAIL     4
`define ST_REMOTE     5
`define ST_LOCK       6
`define ST_ERR        7

// ==========================================================
// limits and timing
`define OCL_MIN_PCT   10
`define OCL_MAX_PCT   110
`define RAMP_MAX      7'h63
`define SLOT_MAX      4'hf
`define FOLD_TIME_MS  500
`define CLK_KHZ       250000
`endif

// ### psu_cmd_pkg.sv
package psu_cmd_pkg;
    // setpoints in hundredths of an ampere or a volt
    typedef logic [15:0] val_type;
    typedef logic [6:0] tenth_s_type;
    typedef logic [3:0] slot_type;
    typedef enum logic {
        PON_OFF = 1'b0,
        PON_LAST = 1'b1
    } pon_type;
endpackage

// ### slot_if.sv
interface slot_if;
    import psu_cmd_pkg::*;
    logic wr_volt;
    logic wr_curr;
    logic clear;
    slot_type idx;
    val_type wdata;
    val_type rd_volt;
    val_type rd_curr;
    modport ctrl (output wr_volt, wr_curr, clear, idx, wdata,
                  input rd_volt, rd_curr);
    modport mem (input wr_volt, wr_curr, clear, idx, wdata,
                 output rd_volt, rd_curr);
endinterface

// ### setting_memory.sv
module setting_memory #(
    parameter int SLOTS = 16
) (
    input wire logic pclk,       // bus clock
    input wire logic presetn,    // async reset, low
    slot_if.mem m                // store, clear and read port
);
    import psu_cmd_pkg::*;
    val_type volt_ff [SLOTS];
    val_type curr_ff [SLOTS];

    // ==========================================================
    // one slot per generate pass; clear wins over a store
    for (genvar g = 0; g < SLOTS; g++) begin : gen_slot
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                volt_ff[g] <= 16'h0000;
                curr_ff[g] <= 16'h0000;
            end else if (m.clear) begin
                volt_ff[g] <= 16'h0000;
                curr_ff[g] <= 16'h0000;
            end else if (m.idx == slot_type'(g)) begin
                if (m.wr_volt) volt_ff[g] <= m.wdata;
                if (m.wr_curr) curr_ff[g] <= m.wdata;
            end
        end
    end

    // read port follows the selected index
    assign m.rd_volt = volt_ff[m.idx];
    assign m.rd_curr = curr_ff[m.idx];

    mem_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        m.clear |=> m.rd_volt == 16'h0000 && m.rd_curr == 16'h0000)
        else $error("slot not erased by memory clear");
endmodule

// ### psu_cmd_top.sv
// Added by the designer: the APB interface to the registers and the register addresses.
`include "psu_cmd_defs.svh"
module psu_cmd_top #(
    parameter psu_cmd_pkg::val_type RATED_CURR = 16'h2710,
    parameter psu_cmd_pkg::val_type RATED_VOLT = 16'h0bb8,
    parameter int unsigned FOLD_CYCLES = `FOLD_TIME_MS * `CLK_KHZ
) (
    input wire logic pclk,                      // bus clock
    input wire logic presetn,                   // async reset, low
    input wire logic psel,                      // apb select
    input wire logic penable,                   // apb access phase
    input wire logic pwrite,                    // apb direction
    input wire logic [11:0] paddr,              // apb byte address
    input wire logic [31:0] pwdata,             // apb write data
    output logic [31:0] prdata,                 // apb read data
    output logic pready,                        // apb ready
    output logic pslverr,                       // unmapped address
    input wire psu_cmd_pkg::pon_type saved_policy, // stored policy
    input wire logic saved_output,              // output before power loss
    input wire logic ov_fault,                  // overvoltage condition
    input wire logic oc_fault,                  // overcurrent condition
    input wire logic ot_fault,                  // overtemperature
    input wire logic acfail,                    // input power fail
    input wire logic cc_mode,                   // constant-current mode
    input wire psu_cmd_pkg::val_type meas_curr, // measured current
    output logic output_on,                     // power stage enable
    output psu_cmd_pkg::pon_type pon_policy,    // policy to save
    output logic out_request,                   // on/off setting to save
    output psu_cmd_pkg::val_type volt_setpoint, // active voltage
    output psu_cmd_pkg::val_type curr_setpoint, // active current
    output psu_cmd_pkg::val_type ocl_active,    // level in force
    output psu_cmd_pkg::tenth_s_type ramp_up,   // ramp-up, 0.1 s units
    output psu_cmd_pkg::tenth_s_type ramp_down, // ramp-down, 0.1 s units
    output logic foldback_en,                   // foldback armed
    output logic oc_tripped                     // overcurrent latched
);
    import psu_cmd_pkg::*;

    localparam val_type OCL_LO =
        16'(32'(RATED_CURR) * `OCL_MIN_PCT / 100);
    localparam val_type OCL_HI =
        16'(32'(RATED_CURR) * `OCL_MAX_PCT / 100);
    localparam int FW = $clog2(FOLD_CYCLES + 1);
    localparam logic [FW-1:0] FOLD_LAST = FW'(FOLD_CYCLES - 1);

    // ==========================================================
    // address decoding
    function automatic logic at(input logic [11:0] a,
                                input logic [7:0] ofs);
        at = (a[11:8] == 4'h0) && (a[7:0] == ofs);
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a[11:8] == 4'h0) && (a[1:0] == 2'b00)
                 && (a[7:0] <= `OFS_SLOT_LIST);
    endfunction

    // ==========================================================
    // state
    logic init_ff;
    pon_type policy_ff;
    logic out_en_ff;
    logic lock_ff;
    logic output_on_ff;
    val_type curr_sp_ff;
    val_type volt_sp_ff;
    val_type ocl_pend_ff;
    val_type ocl_act_ff;
    logic fold_en_ff;
    tenth_s_type ramp_up_ff;
    tenth_s_type ramp_down_ff;
    slot_type slot_sel_ff;
    logic remote_ff;
    logic err_ff;
    logic ov_lat_ff;
    logic oc_lat_ff;
    logic ot_lat_ff;
    logic ac_lat_ff;
    logic [FW-1:0] fold_cnt_ff;
    logic [31:0] prdata_ff;
    slot_if sm ();

    // ==========================================================
    // bus strobes and argument checks
    wire setup = psel && !penable;
    wire wr = psel && penable && pwrite && mapped(paddr);
    wire [15:0] wval = pwdata[15:0];
    wire hi_zero = (pwdata[31:16] == 16'h0000);
    wire w_out = wr && at(paddr, `OFS_OUT_CTRL);
    wire w_pon = wr && at(paddr, `OFS_PON);
    wire w_cmd = wr && at(paddr, `OFS_COMMAND);
    wire w_curr = wr && at(paddr, `OFS_CURR_SP);
    wire w_ocl = wr && at(paddr, `OFS_OCL);
    wire w_fold = wr && at(paddr, `OFS_FOLDBACK);
    wire w_rdown = wr && at(paddr, `OFS_RAMP_DOWN);
    wire w_rup = wr && at(paddr, `OFS_RAMP_UP);
    wire w_sel = wr && at(paddr, `OFS_SLOT_SEL);
    wire w_svolt = wr && at(paddr, `OFS_SLOT_VOLT);
    wire w_scurr = wr && at(paddr, `OFS_SLOT_CURR);
    // out-of-range arguments leave the old setting alone
    wire curr_ok = hi_zero && (wval <= RATED_CURR);
    wire volt_ok = hi_zero && (wval <= RATED_VOLT);
    wire ocl_min = pwdata[`OCL_MIN_BIT];
    wire ocl_max = pwdata[`OCL_MAX_BIT];
    wire ocl_num = (pwdata[29:16] == 14'h0000)
                   && (wval >= OCL_LO) && (wval <= OCL_HI);
    wire ocl_ok = ocl_min || ocl_max || ocl_num;
    wire ramp_ok = (pwdata[31:7] == 25'h0)
                   && (pwdata[6:0] <= `RAMP_MAX);
    wire sel_ok = (pwdata[31:4] == 28'h0);
    wire reject = (w_curr && !curr_ok) || (w_ocl && !ocl_ok)
                  || ((w_rdown || w_rup) && !ramp_ok)
                  || (w_sel && !sel_ok)
                  || ((w_svolt && !volt_ok) || (w_scurr && !curr_ok));
    wire cmd_clear = w_cmd && pwdata[`CMD_FAULT_CLR];
    wire cmd_mclr = w_cmd && pwdata[`CMD_MEM_CLR];
    wire cmd_recall = w_cmd && pwdata[`CMD_RECALL];
    wire cmd_reset = w_cmd && pwdata[`CMD_RESET];
    wire cmd_local = w_cmd && pwdata[`CMD_LOCAL];

    // ==========================================================
    // protection: foldback timer and fault latches
    wire fold_cond = fold_en_ff && cc_mode && (meas_curr > ocl_act_ff);
    wire fold_trip = fold_cond && (fold_cnt_ff == FOLD_LAST);
    wire any_cause = ov_fault || oc_fault || ot_fault || acfail
                     || fold_cond;
    // a clear with any cause still present changes nothing
    wire clr_ok = cmd_clear && !any_cause;
    wire pol_off = (policy_ff == PON_OFF);
    // hardware set wins over a clear in the same cycle
    wire nxt_ov_lat = ov_fault || (ov_lat_ff && !clr_ok);
    wire nxt_oc_lat = oc_fault || fold_trip
                      || (oc_lat_ff && !clr_ok);
    wire nxt_ot_lat = (ot_fault && pol_off)
                      || (ot_lat_ff && !clr_ok);
    wire nxt_ac_lat = (acfail && pol_off)
                      || (ac_lat_ff && !clr_ok);
    // under LAST the unlatched faults still hold the output off
    wire block = ov_lat_ff || oc_lat_ff || ot_lat_ff || ac_lat_ff
                 || ot_fault || acfail;
    // out_en is untouched by faults, so a clear restores it
    wire nxt_output_on = out_en_ff && !block;
    wire [FW-1:0] nxt_fold_cnt = !fold_cond ? '0 :
        (fold_cnt_ff == FOLD_LAST) ? fold_cnt_ff : fold_cnt_ff + 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ov_lat_ff <= 1'b0;
            oc_lat_ff <= 1'b0;
            ot_lat_ff <= 1'b0;
            ac_lat_ff <= 1'b0;
            fold_cnt_ff <= '0;
            output_on_ff <= 1'b0;
        end else begin
            ov_lat_ff <= nxt_ov_lat;
            oc_lat_ff <= nxt_oc_lat;
            ot_lat_ff <= nxt_ot_lat;
            ac_lat_ff <= nxt_ac_lat;
            fold_cnt_ff <= nxt_fold_cnt;
            output_on_ff <= nxt_output_on;
        end
    end

    // ==========================================================
    // power-up policy and output on/off with lock
    // straps are caught on the first edge after release, not in reset
    wire start_on = (saved_policy == PON_LAST) && saved_output;
    wire want_off = w_out && !pwdata[0] && !lock_ff;
    wire nxt_out_en = !init_ff ? start_on :
                      cmd_reset ? 1'b0 :
                      (w_out && pwdata[0]) ? 1'b1 :
                      want_off ? 1'b0 : out_en_ff;
    wire nxt_lock = !init_ff ? start_on :
                    cmd_reset ? 1'b0 : lock_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_ff <= 1'b0;
            policy_ff <= PON_OFF;
            out_en_ff <= 1'b0;
            lock_ff <= 1'b0;
        end else begin
            init_ff <= 1'b1;
            if (!init_ff) policy_ff <= saved_policy;
            else if (w_pon) policy_ff <= pon_type'(pwdata[0]);
            out_en_ff <= nxt_out_en;
            lock_ff <= nxt_lock;
        end
    end

    // ==========================================================
    // setpoints, overcurrent level, ramps, remote state
    // MIN follows the present setpoint, MAX and reset give the ceiling
    wire [15:0] ocl_wval = ocl_max ? OCL_HI :
                           ocl_min ? curr_sp_ff : wval;
    wire nxt_remote = cmd_local ? 1'b0 : (wr && !reject) ? 1'b1
                      : remote_ff;
    wire nxt_err = reject ? 1'b1 : wr ? 1'b0 : err_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            curr_sp_ff <= 16'h0000;
            volt_sp_ff <= 16'h0000;
            fold_en_ff <= 1'b0;
            ramp_up_ff <= 7'h00;
            ramp_down_ff <= 7'h00;
            slot_sel_ff <= 4'h0;
            remote_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            if (cmd_recall) begin
                volt_sp_ff <= sm.rd_volt;
                curr_sp_ff <= sm.rd_curr;
            end else if (w_curr && curr_ok) begin
                curr_sp_ff <= wval;
            end
            if (w_fold) fold_en_ff <= pwdata[0];
            if (w_rup && ramp_ok) ramp_up_ff <= pwdata[6:0];
            if (w_rdown && ramp_ok) ramp_down_ff <= pwdata[6:0];
            if (w_sel && sel_ok) slot_sel_ff <= pwdata[3:0];
            remote_ff <= nxt_remote;
            err_ff <= nxt_err;
        end
    end

    // pending level only reaches the protection while local
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ocl_pend_ff <= OCL_HI;
            ocl_act_ff <= OCL_HI;
        end else begin
            if (cmd_reset) ocl_pend_ff <= OCL_HI;
            else if (w_ocl && ocl_ok) ocl_pend_ff <= ocl_wval;
            if (!remote_ff) ocl_act_ff <= ocl_pend_ff;
        end
    end

    // ==========================================================
    // setting memory
    assign sm.wr_volt = w_svolt && volt_ok;
    assign sm.wr_curr = w_scurr && curr_ok;
    assign sm.clear = cmd_mclr;
    assign sm.idx = slot_sel_ff;
    assign sm.wdata = wval;

    setting_memory #(.SLOTS(16)) u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .m(sm)
    );

    // ==========================================================
    // read mux, captured in the setup phase so prdata is a flop
    wire [31:0] status = {24'h0, err_ff, lock_ff, remote_ff, ac_lat_ff,
                          ot_lat_ff, ov_lat_ff, oc_lat_ff, output_on_ff};
    wire [31:0] rd_mux =
        at(paddr, `OFS_OUT_CTRL) ? {31'h0, out_en_ff} :
        at(paddr, `OFS_PON) ? {31'h0, policy_ff} :
        at(paddr, `OFS_CURR_SP) ? {16'h0, curr_sp_ff} :
        at(paddr, `OFS_OCL) ? {16'h0, ocl_pend_ff} :
        at(paddr, `OFS_FOLDBACK) ? {31'h0, fold_en_ff} :
        at(paddr, `OFS_STATUS) ? status :
        at(paddr, `OFS_RAMP_DOWN) ? {25'h0, ramp_down_ff} :
        at(paddr, `OFS_RAMP_UP) ? {25'h0, ramp_up_ff} :
        at(paddr, `OFS_SLOT_SEL) ? {28'h0, slot_sel_ff} :
        at(paddr, `OFS_SLOT_VOLT) ? {16'h0, sm.rd_volt} :
        at(paddr, `OFS_SLOT_CURR) ? {16'h0, sm.rd_curr} :
        at(paddr, `OFS_VOLT_SP) ? {16'h0, volt_sp_ff} :
        at(paddr, `OFS_OCL_ACT) ? {16'h0, ocl_act_ff} :
        at(paddr, `OFS_SLOT_LIST) ? {sm.rd_volt, sm.rd_curr} :
        32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata_ff <= 32'h0000_0000;
        else if (setup && !pwrite) prdata_ff <= rd_mux;
    end

    // zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata = prdata_ff;
    assign output_on = output_on_ff;
    assign pon_policy = policy_ff;
    assign out_request = out_en_ff;
    assign volt_setpoint = volt_sp_ff;
    assign curr_setpoint = curr_sp_ff;
    assign ocl_active = ocl_act_ff;
    assign ramp_up = ramp_up_ff;
    assign ramp_down = ramp_down_ff;
    assign foldback_en = fold_en_ff;
    assign oc_tripped = oc_lat_ff;

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ov_latch_hold_a: assert property (
        ov_lat_ff && !clr_ok |=> ov_lat_ff)
        else $error("overvoltage latch dropped without clear");
    clear_blocked_a: assert property (
        cmd_clear && any_cause && oc_lat_ff |=> oc_lat_ff)
        else $error("latch cleared while cause present");
    last_no_latch_a: assert property (
        policy_ff == PON_LAST && !ot_lat_ff && !w_pon |=> !ot_lat_ff)
        else $error("overtemperature latched under LAST");
    fold_trip_off_a: assert property (
        fold_trip && !cmd_clear |=> oc_lat_ff ##1 !output_on_ff)
        else $error("foldback did not switch output off");
    lock_keeps_on_a: assert property (
        lock_ff && w_out && !pwdata[0] |=> out_en_ff)
        else $error("output turned off while locked");
    ocl_remote_a: assert property (
        remote_ff |=> $stable(ocl_act_ff))
        else $error("level took effect while remote");
    reject_keeps_a: assert property (
        w_curr && !curr_ok |=> $stable(curr_sp_ff) && err_ff)
        else $error("rejected current value was stored");
    recall_load_a: assert property (
        cmd_recall |=> curr_sp_ff == $past(sm.rd_curr)
                       && volt_sp_ff == $past(sm.rd_volt))
        else $error("recall did not load slot values");
    ocl_max_a: assert property (
        w_ocl && ocl_max |=> ocl_pend_ff == OCL_HI)
        else $error("MAX did not give 110 percent level");
    restore_a: assert property (
        clr_ok && out_en_ff && !ot_fault && !acfail && !cmd_reset
        |=> ##1 output_on_ff)
        else $error("output not restored after clear");
    // straps under OFF must never come up driving the output
    pon_off_start_a: assert property (
        !init_ff && saved_policy == PON_OFF |=> !out_en_ff && !lock_ff)
        else $error("output started on under OFF policy");
    sel_reject_a: assert property (
        w_sel && !sel_ok |=> $stable(slot_sel_ff) && err_ff)
        else $error("rejected slot index was stored");
    ocl_min_a: assert property (
        w_ocl && ocl_min && !ocl_max |=> ocl_pend_ff == $past(curr_sp_ff))
        else $error("MIN did not copy current setpoint");
    fold_write_a: assert property (
        w_fold |=> fold_en_ff == $past(pwdata[0]))
        else $error("foldback enable not stored");

    // main scenarios worth seeing at least once
    fold_trip_c: cover property (fold_trip);
    recall_c: cover property (cmd_recall && output_on_ff);
    clear_ok_c: cover property (clr_ok && oc_lat_ff);
    lock_hold_c: cover property (lock_ff && w_out && !pwdata[0]);
    reject_c: cover property (reject);
endmodule

// ### plant_model.sv
module plant_model (
    input wire logic overload,              // force overcurrent
    input wire psu_cmd_pkg::val_type level, // level in force
    output logic cc_mode,                   // constant-current mode
    output psu_cmd_pkg::val_type meas_curr  // measured current
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // power stage
    // overload sits one step above the level, else well below it
    assign cc_mode = overload;
    assign meas_curr = overload ? level + 16'h0001 : level >> 1;
endmodule

// ### psu_cmd_top_tb.sv
`include "psu_cmd_defs.svh"
module psu_cmd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import psu_cmd_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [7:0] a;
    logic [3:0] flt = 4'h0;
    logic pready, pslverr, slv, saved_output = 1, overload = 0;
    pon_type saved_policy = PON_LAST, pon_policy;
    logic cc_mode, output_on, out_request, foldback_en, oc_tripped;
    val_type meas_curr, volt_setpoint, curr_setpoint, ocl_active;
    tenth_s_type ramp_up, ramp_down;
    int bad_count = 0, comparisons = 0;
    // ==========================================================
    // design and power stage
    psu_cmd_top #(.FOLD_CYCLES(20)) u_psu_cmd_top (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .saved_policy, .saved_output,
        .ov_fault(flt[0]), .oc_fault(flt[1]), .ot_fault(flt[2]),
        .acfail(flt[3]), .cc_mode, .meas_curr, .output_on, .pon_policy,
        .out_request, .volt_setpoint, .curr_setpoint, .ocl_active,
        .ramp_up, .ramp_down, .foldback_en, .oc_tripped);
    plant_model u_plant_model (.overload, .level(ocl_active), .cc_mode,
        .meas_curr);
    // 4 ns clock
    always #2 pclk = ~pclk;
    // ==========================================================
    // closing report
    task automatic stop_test();
        $display("counts: %0d compared, %0d bad", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // one comparison, four-state so x never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // apb transfer; an idle edge first so psel is never driven twice
    task automatic xfer(input logic w, input logic [7:0] ad,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {4'h0, ad};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) begin
            bad_count++;
            stop_test();
        end
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        xfer(1'b1, ad, d);
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
        xfer(1'b0, ad, 32'h0000_0000);
        chk(rd, e);
    endtask
    task automatic stat(input int k, input logic e);
        xfer(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk({31'h0, rd[k]}, {31'h0, e});
    endtask
    task automatic hit(input int k);
        flt[k] <= 1'b1;
        repeat (4) @(posedge pclk);
        flt[k] <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({16'h0000, ocl_active}, 32'h0000_2af8);
        chk({31'h0, output_on}, 32'h0000_0001);
        rd = {30'h0, pon_policy, out_request};
        chk(rd, 32'h0000_0003);
        rchk(`OFS_PON, 32'h0000_0001);
        wr(`OFS_OUT_CTRL, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        chk({31'h0, output_on}, 32'h0000_0001);
        wr(`OFS_COMMAND, 32'h0000_0008);
        repeat (3) @(posedge pclk);
        chk({31'h0, output_on}, 32'h0000_0000);
        for (int k = 2; k < 4; k++) begin
            hit(k);
            stat(k + 1, 1'b0);
        end
        wr(`OFS_PON, 32'h0000_0000);
        rchk(`OFS_PON, 32'h0000_0000);
        for (int k = 2; k < 4; k++) begin
            hit(k);
            stat(k + 1, 1'b1);
            wr(`OFS_COMMAND, 32'h0000_0001);
            stat(k + 1, 1'b0);
        end
        $display("test power_up done");
        wr(`OFS_OUT_CTRL, 32'h0000_0001);
        flt[0] <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({31'h0, output_on}, 32'h0000_0000);
        wr(`OFS_COMMAND, 32'h0000_0001);
        stat(`ST_OV, 1'b1);
        flt[0] <= 1'b0;
        wr(`OFS_COMMAND, 32'h0000_0001);
        stat(`ST_OV, 1'b0);
        chk({31'h0, output_on}, 32'h0000_0001);
        $display("test fault_clear done");
        wr(`OFS_CURR_SP, 32'h0000_2710);
        wr(`OFS_CURR_SP, 32'h0000_2711);
        stat(`ST_ERR, 1'b1);
        rchk(`OFS_CURR_SP, 32'h0000_2710);
        wr(`OFS_OCL, 32'h0000_03e7);
        stat(`ST_ERR, 1'b1);
        wr(`OFS_OCL, 32'h0000_03e8);
        rchk(`OFS_OCL, 32'h0000_03e8);
        chk({16'h0000, ocl_active}, 32'h0000_2af8);
        wr(`OFS_COMMAND, 32'h0000_0010);
        repeat (3) @(posedge pclk);
        chk({16'h0000, ocl_active}, 32'h0000_03e8);
        wr(`OFS_CURR_SP, 32'h0000_0500);
        wr(`OFS_OCL, 32'h4000_0000);
        rchk(`OFS_OCL, 32'h0000_0500);
        wr(`OFS_OCL, 32'h8000_0000);
        rchk(`OFS_OCL, 32'h0000_2af8);
        wr(`OFS_OCL, 32'h0000_03e8);
        $display("test level done");
        // local again so the written level is the one in force
        wr(`OFS_FOLDBACK, 32'h0000_0001);
        rchk(`OFS_FOLDBACK, 32'h0000_0001);
        chk({31'h0, foldback_en}, 32'h0000_0001);
        wr(`OFS_COMMAND, 32'h0000_0010);
        repeat (3) @(posedge pclk);
        overload <= 1'b1;
        repeat (15) @(posedge pclk);
        chk({31'h0, oc_tripped}, 32'h0000_0000);
        repeat (10) @(posedge pclk);
        chk({31'h0, output_on}, 32'h0000_0000);
        stat(`ST_TRIP, 1'b1);
        overload <= 1'b0;
        wr(`OFS_COMMAND, 32'h0000_0001);
        stat(`ST_TRIP, 1'b0);
        wr(`OFS_FOLDBACK, 32'h0000_0000);
        rchk(`OFS_FOLDBACK, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            a = (i == 0) ? `OFS_RAMP_UP : `OFS_RAMP_DOWN;
            wr(a, 32'h0000_0063);
            wr(a, 32'h0000_0064);
            rchk(a, 32'h0000_0063);
        end
        chk({18'h0, ramp_up, ramp_down}, 32'h0000_31e3);
        $display("test foldback_ramp done");
        wr(`OFS_OUT_CTRL, 32'h0000_0000);
        wr(`OFS_SLOT_SEL, 32'h0000_000f);
        wr(`OFS_SLOT_VOLT, 32'h0000_0bb8);
        wr(`OFS_SLOT_CURR, 32'h0000_2710);
        wr(`OFS_SLOT_SEL, 32'h0000_0010);
        wr(`OFS_SLOT_VOLT, 32'h0000_0bb9);
        wr(`OFS_SLOT_CURR, 32'h0000_2711);
        rchk(`OFS_SLOT_SEL, 32'h0000_000f);
        rchk(`OFS_SLOT_LIST, 32'h0bb8_2710);
        rchk(`OFS_SLOT_VOLT, 32'h0000_0bb8);
        wr(`OFS_COMMAND, 32'h0000_0004);
        repeat (2) @(posedge pclk);
        chk({volt_setpoint, curr_setpoint}, 32'h0bb8_2710);
        chk({31'h0, output_on}, 32'h0000_0000);
        wr(`OFS_COMMAND, 32'h0000_0002);
        rchk(`OFS_SLOT_LIST, 32'h0000_0000);
        wr(`OFS_OUT_CTRL, 32'h0000_0001);
        wr(`OFS_COMMAND, 32'h0000_0004);
        repeat (2) @(posedge pclk);
        chk({volt_setpoint, 15'h0, output_on}, 32'h0000_0001);
        xfer(1'b0, 8'h3c, 32'h0000_0000);
        chk({slv, rd[30:0]}, 32'h8000_0000);
        $display("test memory done");
        // second power-up, OFF policy: output stays off despite saved on
        saved_policy <= PON_OFF;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        rd = {29'h0, output_on, pon_policy, out_request};
        chk(rd, 32'h0000_0000);
        rchk(`OFS_PON, 32'h0000_0000);
        $display("test reset done");
        stop_test();
    end
endmodule
